// ### design/csrh_dev.sv
`timescale 1ns/1ps
// Operation
// - host master-clears, waits for run
// - host sets request and input enable together
// - grant sets ready-in, input interrupt
// - host loads data words, then code
// - host drops request before last command
// - bit three selects extended command format
// - response loads data, then ready-out
// - ready-out raises separate output interrupt
// - clearing ready-out frees the port
// - host enables output interrupt after run
// - grant only while microcode idle
// - held request regrants once port free
// - no-request control command is ignored
// - success codes octal 33 and 305
// - failed self-test leaves code, halts
// - host defines mode when software selectable
// - host works in interrupt mode
// - enables at bits zero and four
module csrh_dev #(
  parameter int unsigned INIT_CYCLES = csrh_pkg::INIT_CYCLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  csrh_if.dev              bus,
  input  wire logic        uc_busy,
  input  wire logic        rsp_valid,
  output logic             rsp_ready,
  input  wire logic [2:0]  rsp_code,
  input  wire logic [7:0]  rsp_trib,
  input  wire logic [15:0] rsp_low,
  input  wire logic [15:0] rsp_high,
  output logic             cmd_valid,
  output logic [2:0]       cmd_code,
  output logic             cmd_ext,
  output logic [15:0]      cmd_low,
  output logic [15:0]      cmd_high,
  output logic             run,
  input  wire logic        diag_fail,
  input  wire logic [7:0]  diag_code
);
  // -------------------------------------------
  // state
  // -------------------------------------------
  typedef enum logic [1:0] {
    D_IDLE,
    D_INIT,
    D_POST
  } csrh_dst_t;

  typedef struct packed {
    csrh_dst_t       st;
    logic [15:0]     cnt;
    logic            failed;
    logic            request_in;
    logic            input_interrupt_enable;
    logic            output_interrupt_enable;
    logic            run;
    logic [2:0]      code;
    logic            ext;
    logic            ready_in;
    logic            ready_out;
    logic [7:0]      trib;
    logic [3:0][7:0] dat;
    logic [2:0]      pcode;
    logic            cmdv;
    logic [7:0]      rdata;
  } csrh_dstate_t;

  localparam logic [15:0] INIT_LAST = 16'(INIT_CYCLES - 1);

  csrh_dstate_t s_ff;
  csrh_dstate_t nxt_s;
  logic         wr;
  logic         rd;
  logic         mclr;
  logic         free;

  // -------------------------------------------
  // byte read decode
  // -------------------------------------------
  function automatic logic [7:0] csrh_byte(input csrh_dstate_t s, input logic [2:0] a);
    logic [7:0] b;
    b = 8'h00;
    case (a)
      csrh_pkg::A_CTL: begin
        b[csrh_pkg::B_RQI] = s.request_in;
        b[csrh_pkg::B_IEI] = s.input_interrupt_enable;
        b[csrh_pkg::B_IEO] = s.output_interrupt_enable;
      end
      csrh_pkg::A_MNT: begin
        b[csrh_pkg::B_RUN] = s.run;
        b[csrh_pkg::B_MC]  = (s.st == D_INIT);
      end
      csrh_pkg::A_CMD: begin
        b[2:0]             = s.code;
        b[csrh_pkg::B_EXT] = s.ext;
        b[csrh_pkg::B_RDI] = s.ready_in;
        b[csrh_pkg::B_RDO] = s.ready_out;
      end
      csrh_pkg::A_TRIB: b = s.trib;
      default: b = s.dat[a[1:0]];
    endcase
    return b;
  endfunction : csrh_byte

  assign wr   = bus.csr_sel & bus.csr_we;
  assign rd   = bus.csr_sel & ~bus.csr_we;
  assign mclr = wr & (bus.csr_addr == csrh_pkg::A_MNT) & bus.csr_wdata[csrh_pkg::B_MC];
  // port is ours only when host owns nothing and microcode is idle
  assign free = (s_ff.st == D_IDLE) & s_ff.run & ~s_ff.failed & ~uc_busy & ~s_ff.ready_in & ~s_ff.ready_out & ~mclr;

  // -------------------------------------------
  // next state
  // -------------------------------------------
  always_comb begin
    nxt_s      = s_ff;
    nxt_s.cmdv = 1'b0;
    if (rd) begin
      nxt_s.rdata = csrh_byte(s_ff, bus.csr_addr);
    end
    if (wr) begin
      case (bus.csr_addr)
        csrh_pkg::A_CTL: begin
          nxt_s.request_in = bus.csr_wdata[csrh_pkg::B_RQI];
          nxt_s.input_interrupt_enable = bus.csr_wdata[csrh_pkg::B_IEI];
          nxt_s.output_interrupt_enable = bus.csr_wdata[csrh_pkg::B_IEO];
        end
        csrh_pkg::A_MNT: begin
          nxt_s.run = s_ff.run;
        end
        csrh_pkg::A_CMD: begin
          nxt_s.ext = bus.csr_wdata[csrh_pkg::B_EXT];
          if (s_ff.ready_in) begin
            nxt_s.code = bus.csr_wdata[2:0];
            nxt_s.ready_in  = 1'b0;
            // control command keyed as no request carries nothing
            nxt_s.cmdv = ~((bus.csr_wdata[2:0] == csrh_pkg::CMD_CONTROL) &
                           (s_ff.dat[0][2:0] == csrh_pkg::KEY_NONE));
          end
          if (!bus.csr_wdata[csrh_pkg::B_RDO]) begin
            nxt_s.ready_out = 1'b0;
          end
        end
        csrh_pkg::A_TRIB: nxt_s.trib = bus.csr_wdata;
        default: nxt_s.dat[bus.csr_addr[1:0]] = bus.csr_wdata;
      endcase
    end
    case (s_ff.st)
      D_IDLE: begin
        if (free && rsp_valid) begin
          // data first, ready-out a cycle later
          nxt_s.trib   = rsp_trib;
          nxt_s.dat[0] = rsp_low[7:0];
          nxt_s.dat[1] = rsp_low[15:8];
          nxt_s.dat[2] = rsp_high[7:0];
          nxt_s.dat[3] = rsp_high[15:8];
          nxt_s.pcode  = rsp_code;
          nxt_s.st     = D_POST;
        end else if (free && s_ff.request_in) begin
          nxt_s.ready_in = 1'b1;
        end
      end
      D_POST: begin
        nxt_s.ready_out  = 1'b1;
        nxt_s.code = s_ff.pcode;
        nxt_s.st   = D_IDLE;
      end
      D_INIT: begin
        if (s_ff.cnt == 16'h0000) begin
          nxt_s.run    = 1'b1;
          nxt_s.failed = diag_fail;
          nxt_s.dat[0] = csrh_pkg::DIAG_OK4;
          nxt_s.dat[2] = diag_fail ? diag_code : csrh_pkg::DIAG_OK6;
          nxt_s.st     = D_IDLE;
        end else begin
          nxt_s.cnt = s_ff.cnt - 16'h0001;
        end
      end
      default: nxt_s.st = D_IDLE;
    endcase
    if (mclr) begin
      nxt_s.st     = D_INIT;
      nxt_s.cnt    = INIT_LAST;
      nxt_s.run    = 1'b0;
      nxt_s.failed = 1'b0;
      nxt_s.request_in    = 1'b0;
      nxt_s.input_interrupt_enable    = 1'b0;
      nxt_s.output_interrupt_enable    = 1'b0;
      nxt_s.ready_in    = 1'b0;
      nxt_s.ready_out    = 1'b0;
      nxt_s.cmdv   = 1'b0;
    end
  end

  // -------------------------------------------
  // registers
  // -------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff <= '0;
    end else if (ce) begin
      s_ff <= nxt_s;
    end
  end

  // -------------------------------------------
  // outputs
  // -------------------------------------------
  assign rsp_ready     = ce & free;
  assign bus.csr_rdata = s_ff.rdata;
  assign bus.irq_in    = s_ff.ready_in & s_ff.input_interrupt_enable;
  // distinct line stands for the output vector
  assign bus.irq_out   = s_ff.ready_out & s_ff.output_interrupt_enable;
  assign cmd_valid     = s_ff.cmdv;
  assign cmd_code      = s_ff.code;
  assign cmd_ext       = s_ff.ext;
  assign cmd_low       = {s_ff.dat[1], s_ff.dat[0]};
  assign cmd_high      = {s_ff.dat[3], s_ff.dat[2]};
  assign run           = s_ff.run;
endmodule : csrh_dev

// ### design/csrh_host.sv
`timescale 1ns/1ps
module csrh_host (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq,
  csrh_if.host             bus
);
  // -------------------------------------------
  // state
  // -------------------------------------------
  typedef enum logic [3:0] {
    H_IDLE, H_MC, H_POLL, H_IEO, H_DIAG, H_REQ, H_WAIT, H_DATA, H_RQI, H_CODE, H_RSP, H_RDO
  } csrh_hst_t;

  typedef struct packed {
    csrh_hst_t       st;
    logic [1:0]      ph;
    logic [2:0]      idx;
    logic [7:0][7:0] rb;
    logic            go;
    logic            series;
    logic            rqs;
    logic [3:0]      cmd;
    logic [15:0]     clow;
    logic [15:0]     chigh;
    logic            started;
    logic [2:0]      istat;
    logic [2:0]      imask;
    logic            aw_ok;
    logic [7:0]      aw_a;
    logic            w_ok;
    logic [31:0]     w_d;
    logic            bv;
    logic [1:0]      br;
    logic            rv;
    logic [33:0]     rr;
    logic            sel;
    logic            we;
    logic [2:0]      addr;
    logic [7:0]      wd;
  } csrh_hstate_t;

  localparam logic [7:0] EN_BOTH = 8'h11;
  localparam logic [7:0] EN_REQ  = 8'h91;

  csrh_hstate_t s_ff;
  csrh_hstate_t nxt_s;
  logic [2:0]   iset;
  logic         rclr;
  logic         done;
  logic         diag_ok;
  logic [33:0]  aw_look;

  assign diag_ok = s_ff.started & (s_ff.rb[4] == csrh_pkg::DIAG_OK4) & (s_ff.rb[6] == csrh_pkg::DIAG_OK6);

  function automatic logic [33:0] csrh_rd(input csrh_hstate_t s, input logic ok, input logic [7:0] a);
    logic [33:0] r;
    r = {csrh_pkg::RESP_OKAY, 32'h0000_0000};
    case (a)
      csrh_pkg::R_CMD:   r[3:0] = s.cmd;
      csrh_pkg::R_CLOW:  r[15:0] = s.clow;
      csrh_pkg::R_CHIGH: r[15:0] = s.chigh;
      csrh_pkg::R_STAT:  r[23:0] = {s.rb[4], s.rb[6], 5'h00, ok, s.go, s.started};
      csrh_pkg::R_RSP:   r[15:0] = {s.rb[3], 5'h00, s.rb[2][2:0]};
      csrh_pkg::R_RLOW:  r[15:0] = {s.rb[5], s.rb[4]};
      csrh_pkg::R_RHIGH: r[15:0] = {s.rb[7], s.rb[6]};
      csrh_pkg::R_ISTAT: r[2:0] = s.istat;
      csrh_pkg::R_IMASK: r[2:0] = s.imask;
      csrh_pkg::R_CTRL:  r[2:0] = 3'h0;
      default:           r[33:32] = csrh_pkg::RESP_SLVERR;
    endcase
    return r;
  endfunction : csrh_rd

  // write response code comes from the same decode as reads
  assign aw_look = csrh_rd(s_ff, diag_ok, s_ff.aw_a);

  // -------------------------------------------
  // next state
  // -------------------------------------------
  always_comb begin
    nxt_s     = s_ff;
    nxt_s.sel = 1'b0;
    nxt_s.we  = 1'b0;
    iset      = 3'h0;
    rclr      = 1'b0;
    done      = (s_ff.ph == 2'h2);
    // axi write channels, taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_s.aw_ok = 1'b1;
      nxt_s.aw_a  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_s.w_ok = 1'b1;
      nxt_s.w_d  = s_axi_wdata;
    end
    if (s_ff.aw_ok && s_ff.w_ok) begin
      nxt_s.aw_ok = 1'b0;
      nxt_s.w_ok  = 1'b0;
      nxt_s.bv    = 1'b1;
      nxt_s.br    = aw_look[33:32];
      case (s_ff.aw_a)
        csrh_pkg::R_CTRL: begin
          if (s_ff.w_d[0] && s_ff.st == H_IDLE) begin
            nxt_s.st      = H_MC;
            nxt_s.ph      = 2'h0;
            nxt_s.started = 1'b0;
            nxt_s.go      = 1'b0;
            nxt_s.rqs     = 1'b0;
          end else if (s_ff.w_d[1] && s_ff.started && !s_ff.go) begin
            nxt_s.go     = 1'b1;
            nxt_s.series = s_ff.w_d[2];
          end
        end
        csrh_pkg::R_CMD:   nxt_s.cmd = s_ff.w_d[3:0];
        csrh_pkg::R_CLOW:  nxt_s.clow = s_ff.w_d[15:0];
        csrh_pkg::R_CHIGH: nxt_s.chigh = s_ff.w_d[15:0];
        csrh_pkg::R_IMASK: nxt_s.imask = s_ff.w_d[2:0];
        default: nxt_s.bv = 1'b1;
      endcase
    end
    if (s_ff.bv && s_axi_bready) begin
      nxt_s.bv = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_s.rv = 1'b1;
      nxt_s.rr = csrh_rd(s_ff, diag_ok, s_axi_araddr);
      rclr     = (s_axi_araddr == csrh_pkg::R_ISTAT);
    end
    if (s_ff.rv && s_axi_rready) begin
      nxt_s.rv = 1'b0;
    end
    // each device access is issue, wait, act
    if (s_ff.st != H_IDLE && s_ff.st != H_WAIT) begin
      nxt_s.ph = done ? 2'h0 : s_ff.ph + 2'h1;
    end
    if (s_ff.ph == 2'h0) begin
      nxt_s.sel = (s_ff.st != H_IDLE) && (s_ff.st != H_WAIT);
      nxt_s.addr = s_ff.idx;
    end
    case (s_ff.st)
      H_IDLE: begin
        if (bus.irq_out) begin
          nxt_s.st  = H_RSP;
          nxt_s.idx = csrh_pkg::A_CMD;
        end else if (s_ff.go) begin
          nxt_s.st  = s_ff.rqs ? H_WAIT : H_REQ;
          nxt_s.idx = csrh_pkg::A_CTL;
        end
      end
      H_MC: begin
        nxt_s.we  = 1'b1;
        nxt_s.wd  = 8'h40;
        nxt_s.idx = csrh_pkg::A_MNT;
        nxt_s.addr = csrh_pkg::A_MNT;
        if (done) nxt_s.st = H_POLL;
      end
      H_POLL: begin
        if (done && bus.csr_rdata[csrh_pkg::B_RUN]) begin
          nxt_s.st  = H_IEO;
          nxt_s.idx = csrh_pkg::A_CTL;
        end
      end
      H_IEO: begin
        nxt_s.we = 1'b1;
        nxt_s.wd = EN_BOTH;
        if (done) begin
          nxt_s.st  = H_DIAG;
          nxt_s.idx = csrh_pkg::A_D4;
        end
      end
      H_DIAG: begin
        if (done) begin
          nxt_s.rb[s_ff.idx] = bus.csr_rdata;
          nxt_s.idx          = s_ff.idx + 3'h1;
          if (s_ff.idx == csrh_pkg::A_D7) begin
            nxt_s.st      = H_IDLE;
            nxt_s.started = 1'b1;
            iset[csrh_pkg::I_START] = 1'b1;
          end
        end
      end
      H_REQ: begin
        nxt_s.we = 1'b1;
        nxt_s.wd = EN_REQ;
        if (done) begin
          nxt_s.st  = H_WAIT;
          nxt_s.rqs = 1'b1;
        end
      end
      H_WAIT: begin
        if (bus.irq_out) begin
          nxt_s.st  = H_RSP;
          nxt_s.idx = csrh_pkg::A_CMD;
        end else if (bus.irq_in) begin
          nxt_s.st  = H_DATA;
          nxt_s.idx = csrh_pkg::A_D4;
        end
      end
      H_DATA: begin
        nxt_s.we = 1'b1;
        nxt_s.wd = s_ff.idx[1] ? s_ff.chigh[8*s_ff.idx[0] +: 8] : s_ff.clow[8*s_ff.idx[0] +: 8];
        if (done) begin
          nxt_s.idx = s_ff.idx + 3'h1;
          if (s_ff.idx == csrh_pkg::A_D7) begin
            nxt_s.st  = s_ff.series ? H_CODE : H_RQI;
            nxt_s.idx = s_ff.series ? csrh_pkg::A_CMD : csrh_pkg::A_CTL;
          end
        end
      end
      H_RQI: begin
        nxt_s.we = 1'b1;
        nxt_s.wd = EN_BOTH;
        if (done) begin
          nxt_s.st  = H_CODE;
          nxt_s.rqs = 1'b0;
          nxt_s.idx = csrh_pkg::A_CMD;
        end
      end
      H_CODE: begin
        nxt_s.we = 1'b1;
        nxt_s.wd = {4'h0, s_ff.cmd};
        if (done) begin
          nxt_s.st = H_IDLE;
          nxt_s.go = 1'b0;
          iset[csrh_pkg::I_CMD] = 1'b1;
        end
      end
      H_RSP: begin
        if (done) begin
          nxt_s.rb[s_ff.idx] = bus.csr_rdata;
          nxt_s.idx          = s_ff.idx + 3'h1;
          if (s_ff.idx == csrh_pkg::A_D7) begin
            nxt_s.st  = H_RDO;
            nxt_s.idx = csrh_pkg::A_CMD;
          end
        end
      end
      H_RDO: begin
        nxt_s.we = 1'b1;
        nxt_s.wd = 8'h00;
        if (done) begin
          nxt_s.st = H_IDLE;
          iset[csrh_pkg::I_RSP] = 1'b1;
        end
      end
      default: nxt_s.st = H_IDLE;
    endcase
    // set wins over clear-on-read
    nxt_s.istat = (rclr ? 3'h0 : s_ff.istat) | iset;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff <= '0;
    end else if (ce) begin
      s_ff <= nxt_s;
    end
  end

  // -------------------------------------------
  // outputs
  // -------------------------------------------
  assign s_axi_awready = ~s_ff.aw_ok & ~s_ff.bv;
  assign s_axi_wready  = ~s_ff.w_ok & ~s_ff.bv;
  assign s_axi_bvalid  = s_ff.bv;
  assign s_axi_bresp   = s_ff.br;
  assign s_axi_arready = ~s_ff.rv;
  assign s_axi_rvalid  = s_ff.rv;
  assign s_axi_rdata   = s_ff.rr[31:0];
  assign s_axi_rresp   = s_ff.rr[33:32];
  assign irq           = |(s_ff.istat & s_ff.imask);
  assign bus.csr_sel   = s_ff.sel;
  assign bus.csr_we    = s_ff.we & s_ff.sel;
  assign bus.csr_addr  = s_ff.addr;
  assign bus.csr_wdata = s_ff.wd;
endmodule : csrh_host

// ### design/csrh_if.sv
`timescale 1ns/1ps
interface csrh_if;
  logic       csr_sel;
  logic       csr_we;
  logic [2:0] csr_addr;
  logic [7:0] csr_wdata;
  logic [7:0] csr_rdata;
  logic       irq_in;
  logic       irq_out;
  modport dev  (input csr_sel, csr_we, csr_addr, csr_wdata, output csr_rdata, irq_in, irq_out);
  modport host (output csr_sel, csr_we, csr_addr, csr_wdata, input csr_rdata, irq_in, irq_out);
endinterface : csrh_if

// ### design/csrh_pkg.sv
package csrh_pkg;
  // -------------------------------------------
  // device byte map
  // -------------------------------------------
  localparam logic [2:0] A_CTL  = 3'h0;
  localparam logic [2:0] A_MNT  = 3'h1;
  localparam logic [2:0] A_CMD  = 3'h2;
  localparam logic [2:0] A_TRIB = 3'h3;
  localparam logic [2:0] A_D4   = 3'h4;
  localparam logic [2:0] A_D7   = 3'h7;
  localparam int B_IEI = 0;
  localparam int B_IEO = 4;
  localparam int B_RQI = 7;
  localparam int B_MC  = 6;
  localparam int B_RUN = 7;
  localparam int B_EXT = 3;
  localparam int B_RDI = 4;
  localparam int B_RDO = 7;
  localparam logic [7:0] DIAG_OK4    = 8'h1b;
  localparam logic [7:0] DIAG_OK6    = 8'hc5;
  localparam logic [2:0] CMD_CONTROL = 3'h1;
  localparam logic [2:0] KEY_NONE    = 3'h0;
  localparam int unsigned INIT_CYCLES = 16;
  // -------------------------------------------
  // host register map
  // -------------------------------------------
  localparam logic [7:0] R_CTRL  = 8'h00;
  localparam logic [7:0] R_CMD   = 8'h04;
  localparam logic [7:0] R_CLOW  = 8'h08;
  localparam logic [7:0] R_CHIGH = 8'h0c;
  localparam logic [7:0] R_STAT  = 8'h10;
  localparam logic [7:0] R_RSP   = 8'h14;
  localparam logic [7:0] R_RLOW  = 8'h18;
  localparam logic [7:0] R_RHIGH = 8'h1c;
  localparam logic [7:0] R_ISTAT = 8'h20;
  localparam logic [7:0] R_IMASK = 8'h24;
  localparam int I_START = 0;
  localparam int I_CMD   = 1;
  localparam int I_RSP   = 2;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : csrh_pkg

// ### tb/csrh_properties.sv
`timescale 1ns/1ps
module csrh_properties (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       csr_sel,
  input wire logic       csr_we,
  input wire logic [2:0] csr_addr,
  input wire logic [7:0] csr_wdata,
  input wire logic [7:0] csr_rdata,
  input wire logic       irq_in,
  input wire logic       irq_out
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic wr_ctl, wr_cmd, wr_mc;
  assign wr_ctl = csr_sel && csr_we && csr_addr == csrh_pkg::A_CTL;
  assign wr_cmd = csr_sel && csr_we && csr_addr == csrh_pkg::A_CMD;
  assign wr_mc  = csr_sel && csr_we && csr_addr == csrh_pkg::A_MNT && csr_wdata[csrh_pkg::B_MC];
  // last control byte written; master clear wipes the enables
  logic [7:0] ctl_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn || wr_mc) begin
      ctl_ff <= 8'h00;
    end else if (wr_ctl) begin
      ctl_ff <= csr_wdata;
    end
  end
  // ----------------------------------------
  // link properties
  // ----------------------------------------
  step_gap_a: assert property (csr_sel |=> !csr_sel [*2])
    else $error("access strobes closer than three cycles");
  in_enable_a: assert property (irq_in |-> ctl_ff[csrh_pkg::B_IEI])
    else $error("input irq with input enable clear");
  out_enable_a: assert property (irq_out |-> ctl_ff[csrh_pkg::B_IEO])
    else $error("output irq with output enable clear");
  rdo_release_a: assert property (wr_cmd && !csr_wdata[csrh_pkg::B_RDO] |=> !irq_out)
    else $error("ready out survived its clear");
  code_take_a: assert property (wr_cmd && irq_in |=> !irq_in)
    else $error("ready in kept after code write");
  port_excl_a: assert property (!(irq_in && irq_out))
    else $error("ready in and ready out together");
  post_order_a: assert property ($rose(irq_out) |-> !$past(irq_in))
    else $error("response posted while ready in set");
  rdata_hold_a: assert property (!(csr_sel && !csr_we) |=> $stable(csr_rdata))
    else $error("read data moved without a read");
  clear_quiet_a: assert property (wr_mc |=> !irq_in && !irq_out)
    else $error("interrupt right after master clear");
endmodule : csrh_properties

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam int unsigned INIT_N = 4;  // short init keeps restarts cheap
  logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, uc_busy = 1'b0, rsp_valid = 1'b0, diag_fail = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, rsp_trib = 8'h00, diag_code = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [2:0]  rsp_code = 3'h0;
  logic [15:0] rsp_low = 16'h0, rsp_high = 16'h0;
  logic        awready, wready, bvalid, arready, rvalid, irq, rsp_ready, cmd_valid, cmd_ext, run;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [2:0]  cmd_code, last_a, pre_code;
  logic [15:0] cmd_low, cmd_high;
  logic [7:0]  ctl_w, req_w;
  logic [35:0] cmd_seen;
  int          n_cmd = 0, failures = 0, n_checks = 0;
  always #5 aclk = ~aclk;
  csrh_if cif ();
  csrh_dev #(.INIT_CYCLES(INIT_N)) csrh_dev_inst (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .bus(cif.dev),
    .uc_busy(uc_busy), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_code(rsp_code), .rsp_trib(rsp_trib),
    .rsp_low(rsp_low), .rsp_high(rsp_high), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_ext(cmd_ext),
    .cmd_low(cmd_low), .cmd_high(cmd_high), .run(run), .diag_fail(diag_fail), .diag_code(diag_code));
  csrh_host csrh_host_inst (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq),
    .bus(cif.host));
  csrh_properties csrh_properties_inst (.aclk(aclk), .aresetn(aresetn), .csr_sel(cif.csr_sel),
    .csr_we(cif.csr_we), .csr_addr(cif.csr_addr), .csr_wdata(cif.csr_wdata), .csr_rdata(cif.csr_rdata),
    .irq_in(cif.irq_in), .irq_out(cif.irq_out));
  // ----------------------------------------
  // monitors
  // ----------------------------------------
  always @(posedge aclk) begin
    if (cmd_valid === 1'b1) begin
      n_cmd <= n_cmd + 1;
      cmd_seen <= {cmd_ext, cmd_code, cmd_high, cmd_low};
    end
    if (cif.csr_sel === 1'b1 && cif.csr_we === 1'b1) begin
      last_a <= cif.csr_addr;
      if (cif.csr_addr === csrh_pkg::A_CMD && cif.irq_in === 1'b1) pre_code <= last_a;
      if (cif.csr_addr === csrh_pkg::A_CTL) ctl_w <= cif.csr_wdata;
      if (cif.csr_addr === csrh_pkg::A_CTL && cif.csr_wdata[7] === 1'b1) req_w <= cif.csr_wdata;
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axr
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    axr(a);
    chk(36'(d & m), 36'(e));
  endtask : rd
  task automatic wirq();
    do @(posedge aclk); while (irq !== 1'b1);
  endtask : wirq
  task automatic waitc(input int n);
    while (n_cmd < n) @(posedge aclk);
  endtask : waitc
  // one command in flight: wait until the host has none pending
  task automatic issue(input logic [3:0] c, input logic [15:0] lo, input logic [15:0] hi, input logic ser);
    do axr(csrh_pkg::R_STAT); while (d[1] !== 1'b0);
    axw(csrh_pkg::R_CMD, {28'h0, c});
    axw(csrh_pkg::R_CLOW, {16'h0, lo});
    axw(csrh_pkg::R_CHIGH, {16'h0, hi});
    axw(csrh_pkg::R_CTRL, {29'h0, ser, 2'b10});
  endtask : issue
  task automatic start(input logic f, input logic [7:0] code);
    diag_fail <= f;
    diag_code <= code;
    axw(csrh_pkg::R_CTRL, 32'h1);
    wirq();
    rd(csrh_pkg::R_ISTAT, '1, 32'h1);
  endtask : start
  task automatic rsp(input int i);
    @(posedge aclk);
    rsp_valid <= 1'b1;
    rsp_code <= 3'(i + 2);
    rsp_trib <= 8'(8'h30 + i);
    rsp_low <= 16'(16'h5a00 + i);
    rsp_high <= 16'(16'ha500 + i);
    do @(posedge aclk); while (rsp_ready !== 1'b1);
    rsp_valid <= 1'b0;
    {rsp_low, rsp_high} <= ~{rsp_low, rsp_high};
  endtask : rsp
  task automatic end_of_test();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (30000) @(posedge aclk);
    failures++;
    end_of_test();
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(36'(run), 36'h0);
    rd(csrh_pkg::R_STAT, '1, 32'h0);
    axr(8'h28);
    chk(36'({d[31:2], r}), 36'h2);
    axw(8'h28, 32'h0);
    chk(36'(r), 36'h2);
    axw(csrh_pkg::R_IMASK, 32'h7);
    start(1'b0, 8'h00);
    chk(36'(run), 36'h1);
    rd(csrh_pkg::R_STAT, '1, {8'h00, csrh_pkg::DIAG_OK4, csrh_pkg::DIAG_OK6, 8'h05});
    // masked: status sticks while the line stays low
    axw(csrh_pkg::R_IMASK, 32'h0);
    issue(4'hb, 16'h1234, 16'habcd, 1'b0);
    waitc(1);
    chk(36'(irq), 36'h0);
    chk(cmd_seen, {4'hb, 16'habcd, 16'h1234});
    chk(36'(req_w), 36'h91);
    chk(36'(ctl_w), 36'h11);
    chk(36'(pre_code), 36'(csrh_pkg::A_CTL));
    rd(csrh_pkg::R_ISTAT, '1, 32'h2);
    rd(csrh_pkg::R_ISTAT, '1, 32'h0);
    axw(csrh_pkg::R_IMASK, 32'h7);
    // control with key none is dropped, the next one passes
    issue({1'b0, csrh_pkg::CMD_CONTROL}, 16'h0010, 16'h0, 1'b0);
    issue(4'h2, 16'h0011, 16'h0, 1'b0);
    waitc(2);
    rd(csrh_pkg::R_ISTAT, '1, 32'h2);
    chk(cmd_seen, {4'h2, 16'h0, 16'h0011});
    chk(36'(n_cmd), 36'h2);
    uc_busy <= 1'b1;
    issue(4'h5, 16'h0f0f, 16'hf0f0, 1'b0);
    repeat (40) @(posedge aclk);
    chk(36'(n_cmd), 36'h2);
    rd(csrh_pkg::R_STAT, 32'h2, 32'h2);
    uc_busy <= 1'b0;
    waitc(3);
    chk(cmd_seen, {4'h5, 16'hf0f0, 16'h0f0f});
    // every code, held request until the last
    for (int c = 0; c < 8; c++) begin
      issue(4'(c + 8 * (c % 2)), 16'h00f7, 16'(c), c < 7);
      waitc(4 + c);
      chk(cmd_seen, {1'(c % 2), 3'(c), 16'(c), 16'h00f7});
      chk(36'(pre_code), (c < 7) ? 36'(csrh_pkg::A_D7) : 36'(csrh_pkg::A_CTL));
    end
    // command status from the series above must be gone before waiting on irq
    rd(csrh_pkg::R_ISTAT, '1, 32'h2);
    // second response needs the port back
    for (int i = 0; i < 2; i++) begin
      rsp(i);
      wirq();
      rd(csrh_pkg::R_ISTAT, '1, 32'h4);
      rd(csrh_pkg::R_RSP, '1, {16'h0, 8'(8'h30 + i), 5'h0, 3'(i + 2)});
      rd(csrh_pkg::R_RLOW, '1, 32'(16'h5a00 + i));
      rd(csrh_pkg::R_RHIGH, '1, 32'(16'ha500 + i));
    end
    // failed self-test codes, octal 101 and 21
    for (int k = 0; k < 2; k++) begin
      start(1'b1, k ? 8'h11 : 8'h41);
      rd(csrh_pkg::R_STAT, 32'hff04, {16'h0, k ? 8'h11 : 8'h41, 8'h00});
    end
    issue(4'h3, 16'h0007, 16'h0, 1'b0);
    repeat (40) @(posedge aclk);
    chk(36'(n_cmd), 36'd11);
    end_of_test();
  end
endmodule : tb
